// ---- common/ptb_defs.svh ----
// constants for the preset timer bank: offsets, fields, resets, timing
`ifndef PTB_DEFS_SVH
`define PTB_DEFS_SVH
// word addresses on the register port
`define PTB_CUR_BASE 8'h00
`define PTB_PRE_BASE 8'h10
`define PTB_CTRL 8'h20
`define PTB_STATUS 8'h21
`define PTB_IRQ_STAT 8'h22
`define PTB_IRQ_MASK 8'h23
// control word field positions
`define PTB_CTRL_SFAST 0
`define PTB_CTRL_AFAST 8
`define PTB_CTRL_AKPRE 12
// done and event bit position of accumulating timers
`define PTB_ACC_BIT 8
// reset values
`define PTB_PRE_RST 16'h0000
`define PTB_CTRL_RST 16'h0000
`define PTB_MASK_RST 16'h0000
// count ceilings (0.1 s or 0.01 s units)
`define PTB_SGL_MAX 16'h270F
`define PTB_ACC_MAX 32'h05F5_E0FF
// timebase
`define PTB_CLK_MHZ 100
`define PTB_HUND_US 10000
`define PTB_TENTH_US 100000
`define PTB_HUND_CYC (`PTB_HUND_US * `PTB_CLK_MHZ)
`define PTB_TENTH_DIV (`PTB_TENTH_US / `PTB_HUND_US)
`endif

// ---- common/ptb_pkg.sv ----
// shared types of the preset timer bank
package ptb_pkg;
  typedef logic [15:0] ptb_word_t; // one storage word
  typedef logic [31:0] ptb_long_t; // two-word accumulated value
  typedef enum logic [0:0] {
    PTB_RATE_TENTH = 1'h0,
    PTB_RATE_HUND  = 1'h1
  } ptb_rate_t;
endpackage

// ---- common/ptb_tick_if.sv ----
// timebase tick pulses passed from the divider to the timer bank
`timescale 1ns/1ps
`default_nettype none
interface ptb_tick_if;
  logic tick_hund;  // one-cycle pulse every 0.01 s
  logic tick_tenth; // one-cycle pulse every 0.1 s
  modport src (output tick_hund, output tick_tenth);
  modport dst (input tick_hund, input tick_tenth);
endinterface
`default_nettype wire

// ---- sim/ptb_rung_model.sv ----
// rung logic model driving accumulating timer enable and reset lines
`timescale 1ns/1ps
`default_nettype none
module ptb_rung_model #(
  parameter int N = 2 // accumulating timers driven
) (
  input  wire logic         ref_clk_i, // 100 MHz clock
  output logic      [N-1:0] acc_en_o,  // enable lines
  output logic      [N-1:0] acc_rst_o  // reset lines
);
  // all lines idle off from time zero
  initial begin
    acc_en_o  = '0;
    acc_rst_o = '0;
  end
  // rung result changes just after a clock edge and then holds
  task automatic set_lines(input int j, input logic en, input logic rs);
    @(posedge ref_clk_i);
    acc_en_o[j]  <= en;
    acc_rst_o[j] <= rs;
  endtask
endmodule
`default_nettype wire

// ---- sim/test_preset_timer_bank.sv ----
// self-checking testbench of the preset timer bank
`timescale 1ns/1ps
`default_nettype none
module test_preset_timer_bank;
  logic        ref_clk_i = 1'b0; // bench clock
  logic        rst_i     = 1'b1; // async reset
  logic [3:0]  sgl_in_i  = '0;   // single timer inputs
  logic [7:0]  addr_i    = '0;   // bus address
  logic [15:0] wdata_i   = '0;   // bus write data
  logic        wr_i      = 1'b0; // write strobe
  logic        rd_i      = 1'b0; // read strobe
  logic [1:0]  acc_en, acc_rst;  // from rung model
  logic [15:0] rdata, rdata_s;   // read data of both instances
  logic [3:0]  sgl_done;         // single status bits
  logic [1:0]  acc_done;         // accumulating status bits
  logic        irq;              // interrupt line
  wire  [5:0]  done_all = {acc_done, sgl_done}; // all status bits
  int          err_total  = 0;   // mismatches
  int          n_compared = 0;   // comparisons made
  logic [15:0] v, v1, vs;        // read scratch
  typedef struct { logic [7:0] a; logic [15:0] e; } ptb_row_t;
  ptb_row_t rows [8] = '{'{8'h20, 16'h0000}, '{8'h23, 16'h0000},
    '{8'h10, 16'h0000}, '{8'h15, 16'h0000}, '{8'h21, 16'h0300},
    '{8'h22, 16'h0300}, '{8'h30, 16'h0000}, '{8'h00, 16'h0000}};

  always #5 ref_clk_i = ~ref_clk_i; // 100 MHz

  ptb_rung_model #(.N(2)) u_rung (.ref_clk_i(ref_clk_i),
    .acc_en_o(acc_en), .acc_rst_o(acc_rst));
  // main instance, 0.01 s shortened to 10 cycles
  ptb_top #(.HUND_CYCLES(10), .ACC_K_PRE(32'h0000_0008)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sgl_in_i(sgl_in_i),
    .acc_en_i(acc_en), .acc_rst_i(acc_rst), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
    .sgl_done_o(sgl_done), .acc_done_o(acc_done), .irq_o(irq));
  // fast instance sharing the bus, used for the count ceiling
  ptb_top #(.HUND_CYCLES(2)) u_sat (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sgl_in_i(sgl_in_i),
    .acc_en_i(acc_en), .acc_rst_i(acc_rst), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_s),
    .sgl_done_o(), .acc_done_o(), .irq_o());

  // compare one value and count it
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // print counts and verdict, end the run
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one-cycle write
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask
  // one-cycle read, data sampled in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d,
                    output logic [15:0] ds);
    @(posedge ref_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1;
    d  = rdata;
    ds = rdata_s;
  endtask
  // bounded wait for a status bit to come on
  task automatic wait_bit(input int b, input int lim);
    int n;
    n = 0;
    while (done_all[b] !== 1'b1) begin
      @(posedge ref_clk_i);
      #1;
      n++;
      if (n > lim) begin
        chk(32'h1, 32'h0);
        summarize();
      end
    end
  endtask

  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    // reset values, unmapped word, initial status
    foreach (rows[i]) begin
      rd(rows[i].a, v, vs);
      chk(v, rows[i].e);
    end
    // interrupt: mask, then clear one sticky bit
    chk(irq, 1'b0);
    wr(8'h23, 16'h0100);
    #1 chk(irq, 1'b1);
    wr(8'h22, 16'h0100);
    #1 chk(irq, 1'b0);
    rd(8'h22, v, vs);
    chk(v, 16'h0200);
    // tenth single timer with preset 5
    wr(8'h10, 16'h0005);
    sgl_in_i[0] <= 1'b1;
    repeat (350) @(posedge ref_clk_i);
    rd(8'h00, v, vs);
    chk(v >= 3 && v <= 4, 1'b1);
    chk(sgl_done[0], 1'b0);
    wait_bit(0, 400);
    rd(8'h00, v, vs);
    chk(v, 16'h0005);
    @(posedge ref_clk_i);
    sgl_in_i[0] <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 chk(sgl_done[0], 1'b0);
    rd(8'h00, v, vs);
    chk(v, 16'h0000);
    // singles 1 and 3 and both acc fast, acc1 constant preset
    wr(8'h20, 16'h230A);
    wr(8'h11, 16'h0014);
    #1 chk(acc_done[1], 1'b0);
    @(posedge ref_clk_i);
    sgl_in_i[1] <= 1'b1;
    sgl_in_i[3] <= 1'b1;
    repeat (50) @(posedge ref_clk_i);
    rd(8'h01, v, vs);
    chk(v >= 5 && v <= 6, 1'b1);
    // ceiling of the fast single timer
    repeat (20100) @(posedge ref_clk_i);
    rd(8'h03, v, vs);
    chk(vs, 16'h270F);
    // acc0 preset from two words
    wr(8'h14, 16'h0008);
    wr(8'h15, 16'h0000);
    #1 chk(acc_done[0], 1'b0);
    u_rung.set_lines(0, 1'b1, 1'b0);
    repeat (30) @(posedge ref_clk_i);
    u_rung.set_lines(0, 1'b0, 1'b0);
    rd(8'h04, v1, vs);
    chk(v1 >= 2 && v1 <= 4, 1'b1);
    repeat (60) @(posedge ref_clk_i);
    rd(8'h04, v, vs);
    chk(v, v1);
    rd(8'h05, v, vs);
    chk(v, 16'h0000);
    u_rung.set_lines(0, 1'b1, 1'b0);
    repeat (40) @(posedge ref_clk_i);
    u_rung.set_lines(0, 1'b0, 1'b0);
    rd(8'h04, v, vs);
    chk(v >= v1 + 3 && v <= v1 + 5, 1'b1);
    chk(acc_done[0], v >= 8);
    // reset wins over enable
    u_rung.set_lines(0, 1'b1, 1'b1);
    repeat (30) @(posedge ref_clk_i);
    rd(8'h04, v, vs);
    chk(v, 16'h0000);
    chk(acc_done[0], 1'b0);
    u_rung.set_lines(0, 1'b1, 1'b0);
    repeat (25) @(posedge ref_clk_i);
    rd(8'h04, v, vs);
    chk(v >= 2 && v <= 3, 1'b1);
    // acc1 against the constant preset of 8
    u_rung.set_lines(1, 1'b1, 1'b0);
    wait_bit(5, 150);
    rd(8'h06, v, vs);
    chk(v, 16'h0008);
    summarize();
  end
endmodule
`default_nettype wire

// ---- src/ptb_timebase.sv ----
// timebase divider making 0.01 s and 0.1 s enable pulses
`timescale 1ns/1ps
`default_nettype none
`include "ptb_defs.svh"
module ptb_timebase #(
  parameter int HUND_CYCLES = `PTB_HUND_CYC,
  parameter int TENTH_DIV   = `PTB_TENTH_DIV
) (
  input  wire logic ref_clk_i, // 100 MHz clock
  input  wire logic rst_i,     // async reset, active high
  ptb_tick_if.src   tk         // tick pulses out
);
  localparam int HW = $clog2(HUND_CYCLES + 1);
  // whole divider state
  typedef struct packed {
    logic [HW-1:0] hcnt; // cycles within 0.01 s
    logic [3:0]    tcnt; // hundredths within 0.1 s
    logic          th;   // hundredth pulse
    logic          tt;   // tenth pulse
  } ptb_tb_state_t;
  ptb_tb_state_t st, next_st;
  // next divider state
  always_comb begin
    next_st    = st;
    next_st.th = 1'b0;
    next_st.tt = 1'b0;
    if (st.hcnt == HW'(HUND_CYCLES - 1)) begin
      next_st.hcnt = '0;
      next_st.th   = 1'b1;
      if (st.tcnt == 4'(TENTH_DIV - 1)) begin
        next_st.tcnt = '0;
        next_st.tt   = 1'b1;
      end else begin
        next_st.tcnt = st.tcnt + 4'h1;
      end
    end else begin
      next_st.hcnt = st.hcnt + HW'(1);
    end
  end
  // divider registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign tk.tick_hund  = st.th;
  assign tk.tick_tenth = st.tt;
endmodule
`default_nettype wire

// ---- src/ptb_top.sv ----
// preset timer bank: single-input and accumulating timers, register port
`timescale 1ns/1ps
`default_nettype none
`include "ptb_defs.svh"
module ptb_top #(
  parameter int        N_SGL       = 4,          // single-input timers
  parameter int        N_ACC       = 2,          // accumulating timers
  parameter int        HUND_CYCLES = `PTB_HUND_CYC, // cycles per 0.01 s
  parameter logic [31:0] ACC_K_PRE = 32'h0000_001E // constant preset
) (
  input  wire logic             ref_clk_i, // 100 MHz clock
  input  wire logic             rst_i,     // async reset, active high
  input  wire logic [N_SGL-1:0] sgl_in_i,  // single timer inputs
  input  wire logic [N_ACC-1:0] acc_en_i,  // accumulating enables
  input  wire logic [N_ACC-1:0] acc_rst_i, // accumulating resets
  input  wire logic [7:0]       addr_i,    // register word address
  input  wire logic [15:0]      wdata_i,   // write data
  input  wire logic             wr_i,      // write strobe
  input  wire logic             rd_i,      // read strobe
  output logic      [15:0]      rdata_o,   // read data, next cycle
  output logic      [N_SGL-1:0] sgl_done_o, // single status bits
  output logic      [N_ACC-1:0] acc_done_o, // accumulating status bits
  output logic                  irq_o      // level interrupt
);
  // bank state
  typedef struct packed {
    logic [N_SGL-1:0][15:0] sgl_cur;  // single current values
    logic [N_SGL-1:0][15:0] sgl_pre;  // single presets
    logic [N_ACC-1:0][31:0] acc_cur;  // accumulated values
    logic [N_ACC-1:0][31:0] acc_pre;  // preset word pairs
    logic [N_SGL-1:0]       sgl_done; // single status
    logic [N_ACC-1:0]       acc_done; // accumulating status
    logic [N_SGL-1:0]       sgl_fast; // single rate select
    logic [N_ACC-1:0]       acc_fast; // accumulating rate select
    logic [N_ACC-1:0]       acc_kpre; // use constant preset
    logic [15:0]            irq_stat; // sticky events
    logic [15:0]            irq_mask; // event enables
    logic [15:0]            rdata;    // read data register
  } ptb_state_t;

  ptb_state_t st;      // registered state
  ptb_state_t next_st; // next state

  // tick pulses from the divider
  ptb_tick_if tk ();

  // divider instance
  ptb_timebase #(
    .HUND_CYCLES (HUND_CYCLES),
    .TENTH_DIV   (`PTB_TENTH_DIV)
  ) u_timebase (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .tk        (tk.src)
  );

  // saturating step of a count
  function automatic logic [31:0] sat_inc(
    input logic [31:0] val,
    input logic [31:0] max
  );
    if (val >= max) begin
      sat_inc = max;
    end else begin
      sat_inc = val + 32'h1;
    end
  endfunction

  // tick that belongs to a rate
  function automatic logic pick_tick(input logic fast);
    ptb_pkg::ptb_rate_t r;
    r = ptb_pkg::ptb_rate_t'(fast);
    pick_tick = (r == ptb_pkg::PTB_RATE_HUND) ? tk.tick_hund
                                              : tk.tick_tenth;
  endfunction

  // storage word at index: singles first, then word pairs
  function automatic logic [15:0] pick_word(
    input logic [N_SGL-1:0][15:0] s,
    input logic [N_ACC-1:0][31:0] a,
    input logic [7:0]             idx
  );
    pick_word = 16'h0000;
    for (int i = 0; i < N_SGL; i++) begin
      if (idx == 8'(i)) begin
        pick_word = s[i];
      end
    end
    for (int j = 0; j < N_ACC; j++) begin
      if (idx == 8'(N_SGL + 2 * j)) begin
        pick_word = a[j][15:0];
      end
      if (idx == 8'(N_SGL + 2 * j + 1)) begin
        pick_word = a[j][31:16];
      end
    end
  endfunction

  // event vector and status word
  logic [15:0] done_word;
  logic [15:0] next_done_word;
  logic [15:0] rise;
  logic [15:0] valid_bits;

  // next state of the whole bank
  always_comb begin
    next_st       = st;
    next_st.rdata = 16'h0000;
    // register writes: presets and control
    if (wr_i) begin
      for (int i = 0; i < N_SGL; i++) begin
        if (addr_i == 8'(`PTB_PRE_BASE + i)) begin
          next_st.sgl_pre[i] = wdata_i;
        end
      end
      for (int j = 0; j < N_ACC; j++) begin
        if (addr_i == 8'(`PTB_PRE_BASE + N_SGL + 2 * j)) begin
          next_st.acc_pre[j][15:0] = wdata_i;
        end
        if (addr_i == 8'(`PTB_PRE_BASE + N_SGL + 2 * j + 1)) begin
          next_st.acc_pre[j][31:16] = wdata_i;
        end
      end
      if (addr_i == `PTB_CTRL) begin
        next_st.sgl_fast = wdata_i[`PTB_CTRL_SFAST +: N_SGL];
        next_st.acc_fast = wdata_i[`PTB_CTRL_AFAST +: N_ACC];
        next_st.acc_kpre = wdata_i[`PTB_CTRL_AKPRE +: N_ACC];
      end
      if (addr_i == `PTB_IRQ_MASK) begin
        next_st.irq_mask = wdata_i & valid_bits;
      end
    end
    // single-input timers
    for (int i = 0; i < N_SGL; i++) begin
      if (!sgl_in_i[i]) begin
        next_st.sgl_cur[i] = 16'h0000;
      end else if (pick_tick(st.sgl_fast[i])) begin
        next_st.sgl_cur[i] = 16'(sat_inc({16'h0000, st.sgl_cur[i]},
                                 {16'h0000, `PTB_SGL_MAX}));
      end
      // status from the new value; off with the input
      next_st.sgl_done[i] = sgl_in_i[i] &&
        (next_st.sgl_cur[i] >= next_st.sgl_pre[i]);
    end
    // accumulating timers
    for (int j = 0; j < N_ACC; j++) begin
      if (acc_rst_i[j]) begin
        next_st.acc_cur[j] = 32'h0;
      end else if (acc_en_i[j] && pick_tick(st.acc_fast[j])) begin
        next_st.acc_cur[j] = sat_inc(st.acc_cur[j],
                                     `PTB_ACC_MAX);
      end
      // disabled and not reset: value kept as is
      next_st.acc_done[j] = !acc_rst_i[j] &&
        (next_st.acc_cur[j] >=
         (next_st.acc_kpre[j] ? ACC_K_PRE
                              : next_st.acc_pre[j]));
    end
    // sticky events: set wins over write-one clear
    next_done_word = 16'h0000;
    next_done_word[N_SGL-1:0] = next_st.sgl_done;
    next_done_word[`PTB_ACC_BIT +: N_ACC] = next_st.acc_done;
    // status bits that come on this cycle
    rise = next_done_word & ~done_word;
    if (wr_i && addr_i == `PTB_IRQ_STAT) begin
      next_st.irq_stat = st.irq_stat & ~wdata_i;
    end
    next_st.irq_stat = next_st.irq_stat | rise;
    // read data for the next cycle
    if (rd_i) begin
      if (addr_i < `PTB_PRE_BASE) begin
        next_st.rdata = pick_word(st.sgl_cur, st.acc_cur,
                                  addr_i - `PTB_CUR_BASE);
      end else if (addr_i < `PTB_CTRL) begin
        next_st.rdata = pick_word(st.sgl_pre, st.acc_pre,
                                  addr_i - `PTB_PRE_BASE);
      end else if (addr_i == `PTB_CTRL) begin
        next_st.rdata[`PTB_CTRL_SFAST +: N_SGL] = st.sgl_fast;
        next_st.rdata[`PTB_CTRL_AFAST +: N_ACC] = st.acc_fast;
        next_st.rdata[`PTB_CTRL_AKPRE +: N_ACC] = st.acc_kpre;
      end else if (addr_i == `PTB_STATUS) begin
        next_st.rdata = done_word;
      end else if (addr_i == `PTB_IRQ_STAT) begin
        next_st.rdata = st.irq_stat;
      end else if (addr_i == `PTB_IRQ_MASK) begin
        next_st.rdata = st.irq_mask;
      end
      // unmapped addresses read as zero
    end
  end

  // current status word and its mask of valid bits
  always_comb begin
    done_word = 16'h0000;
    done_word[N_SGL-1:0] = st.sgl_done;
    done_word[`PTB_ACC_BIT +: N_ACC] = st.acc_done;
    valid_bits = 16'h0000;
    valid_bits[N_SGL-1:0] = '1;
    valid_bits[`PTB_ACC_BIT +: N_ACC] = '1;
  end

  // bank registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st          <= '0;
      st.sgl_pre  <= {N_SGL{`PTB_PRE_RST}};
      st.acc_pre  <= {(2 * N_ACC){`PTB_PRE_RST}};
      st.irq_mask <= `PTB_MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs from flip-flops; irq_o gated from irq_stat and irq_mask
  assign rdata_o    = st.rdata;
  assign sgl_done_o = st.sgl_done;
  assign acc_done_o = st.acc_done;
  assign irq_o      = |(st.irq_stat & st.irq_mask);

  // checks on timer 0 of each kind, the ticks and the read port
  default clocking dc @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  // single timer input on and a tick due
  sequence s_sgl_step;
    sgl_in_i[0] && (st.sgl_fast[0] ? tk.tick_hund : tk.tick_tenth);
  endsequence

  // single timer input on but no tick due
  sequence s_sgl_idle;
    sgl_in_i[0] && !(st.sgl_fast[0] ? tk.tick_hund : tk.tick_tenth);
  endsequence

  // accumulating timer enabled, not reset, tick due
  sequence s_acc_step;
    acc_en_i[0] && !acc_rst_i[0] &&
      (st.acc_fast[0] ? tk.tick_hund : tk.tick_tenth);
  endsequence

  sgl_clear_a: assert property (
    !sgl_in_i[0] |=> st.sgl_cur[0] == 16'h0000 && !sgl_done_o[0])
    else $error("single timer not cleared when input off");

  sgl_step_a: assert property (
    s_sgl_step ##0 (st.sgl_cur[0] < `PTB_SGL_MAX)
    |=> st.sgl_cur[0] == $past(st.sgl_cur[0]) + 16'h1)
    else $error("single timer did not advance on tick");

  sgl_ceil_a: assert property (
    st.sgl_cur[0] <= `PTB_SGL_MAX)
    else $error("single timer above its ceiling");

  sgl_done_a: assert property (
    sgl_done_o[0] == (st.sgl_cur[0] >= st.sgl_pre[0]
                      && $past(sgl_in_i[0])))
    else $error("single status disagrees with compare");

  acc_keep_a: assert property (
    !acc_en_i[0] && !acc_rst_i[0] |=> $stable(st.acc_cur[0]))
    else $error("accumulated value changed while disabled");

  acc_reset_a: assert property (
    acc_rst_i[0] [*2] |=> st.acc_cur[0] == 32'h0 && !acc_done_o[0])
    else $error("accumulated value not held at zero");

  acc_sat_a: assert property (
    s_acc_step ##0 (st.acc_cur[0] == `PTB_ACC_MAX)
    |=> st.acc_cur[0] == `PTB_ACC_MAX)
    else $error("accumulating timer wrapped past maximum");

  acc_step_a: assert property (
    s_acc_step ##0 (st.acc_cur[0] < `PTB_ACC_MAX)
    |=> st.acc_cur[0] == $past(st.acc_cur[0]) + 32'h1)
    else $error("accumulating timer did not resume counting");

  // event stays until a one is written to it
  irq_sticky_a: assert property (
    st.irq_stat[`PTB_ACC_BIT] && !(wr_i && addr_i == `PTB_IRQ_STAT
      && wdata_i[`PTB_ACC_BIT]) |=> st.irq_stat[`PTB_ACC_BIT])
    else $error("event cleared without a write of one");

  // a rising accumulating status sets its event
  irq_set_a: assert property (
    $rose(acc_done_o[0]) |-> st.irq_stat[`PTB_ACC_BIT])
    else $error("status rise did not set its event");

  // tenth tick only lands on a hundredth tick
  tick_nest_a: assert property (
    tk.tick_tenth |-> tk.tick_hund)
    else $error("tenth tick without hundredth tick");

  // hundredth ticks are single-cycle pulses
  tick_gap_a: assert property (
    tk.tick_hund |=> !tk.tick_hund)
    else $error("hundredth tick longer than one cycle");

  // no tick due: single value holds
  sgl_hold_a: assert property (
    s_sgl_idle |=> $stable(st.sgl_cur[0]))
    else $error("single timer moved without a tick");

  // accumulated value never above its ceiling
  acc_ceil_a: assert property (
    st.acc_cur[0] <= `PTB_ACC_MAX)
    else $error("accumulating timer above its ceiling");

  // accumulating status against the chosen preset
  acc_done_a: assert property (
    !$past(rst_i) |-> acc_done_o[0] == (!$past(acc_rst_i[0]) &&
      st.acc_cur[0] >= (st.acc_kpre[0] ? ACC_K_PRE : st.acc_pre[0])))
    else $error("accumulating status disagrees with compare");

  // read data stand one cycle, then zero
  rdata_zero_a: assert property (
    !rd_i |=> rdata_o == 16'h0000)
    else $error("read data not zero without a read");

  // word 0 returns timer 0 value
  rdata_cur_a: assert property (
    rd_i && addr_i == `PTB_CUR_BASE |=> rdata_o == $past(st.sgl_cur[0]))
    else $error("value word did not return timer value");

  // word after the low half returns the high half
  acc_word_a: assert property (
    rd_i && addr_i == 8'(`PTB_CUR_BASE + N_SGL + 1)
    |=> rdata_o == $past(st.acc_cur[0][31:16]))
    else $error("high word of accumulated value misread");

  // status word carries the single status bit
  rdata_stat_a: assert property (
    rd_i && addr_i == `PTB_STATUS |=> rdata_o[0] == $past(sgl_done_o[0]))
    else $error("status word disagrees with status bit");
endmodule
`default_nettype wire
